/* File: core/mac_control_register_head.sv */
// Front part of the control and status register bank of the MAC.
`timescale 1ns/100ps
module mac_control_register_head
    import mac_csr_pkg::*;
#(
    parameter logic [15:0] customer_revision_param = 16'h0000,
    // Core revision code; value is arbitrary.
    parameter logic [15:0] CORE_REVISION = 16'h0001
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [mac_csr_pkg::ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [mac_csr_pkg::DATA_W-1:0] writedata_i,
    output logic [mac_csr_pkg::DATA_W-1:0] readdata_o,
    output logic waitrequest_o,
    // Configuration towards the core
    output logic [31:0] control_o,
    output logic [47:0] station_addr_o,
    output logic soft_reinit_o
);
    import mac_csr_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------

    // The read mux and the field slices below are laid out for a 32-bit
    // word and a 9-bit word address; any other geometry is refused here
    // rather than truncated silently.
    if (DATA_W != 32 || ADDR_W != 9) begin : g_bad_geometry
        $error("register head supports only 32-bit data, 9-bit address");
    end

    // The high address word keeps 16 bits; a wider field would overlap
    // the reserved half that must read as zero.
    if (ADDR_HIGH_W != 16) begin : g_bad_addr_high
        $error("high station-address field must be 16 bits wide");
    end

    // The trigger bit must not sit on the two enable bits that the
    // software reset clears, or the word could never be re-enabled.
    if (SOFT_REINIT_BIT < 2 || SOFT_REINIT_BIT > 31) begin : g_bad_reinit
        $error("software-reset bit must lie between bits 2 and 31");
    end

    // Mask of the reinit trigger bit inside the control word.
    localparam logic [31:0] REINIT_MASK = 32'h0000_0001 << SOFT_REINIT_BIT;

    // ------------------------------------------------------------------
    // Access phase
    // ------------------------------------------------------------------

    // One wait cycle on every read so the data comes from a flip-flop;
    // writes complete at once, except a control write that meets the
    // software-reset pulse: that one waits a cycle so the clear cannot
    // swallow it. The host holds its request meanwhile.
    logic read_done_reg;
    logic read_wait;
    logic ctl_wait;
    logic ctl_sel;
    logic [31:0] scratch_word_reg;
    logic [31:0] control_reg;
    logic [31:0] addr_low_reg;
    logic [ADDR_HIGH_W-1:0] addr_high_reg;
    logic [31:0] read_next;
    logic wr_scratch;
    logic wr_control;
    logic wr_low;
    logic wr_high;
    logic reinit_req;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_done_reg <= 1'b0;
        end else begin
            read_done_reg <= read_i && !read_done_reg;
        end
    end

    // A read stalls in its first cycle only.
    assign read_wait = read_i && !read_done_reg;

    // A control write arriving while the pulse stands would be lost to the
    // clear below; holding it one cycle lets it land after the clear.
    assign ctl_wait = write_i && ctl_sel && soft_reinit_o;

    assign waitrequest_o = read_wait || ctl_wait;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------

    // Word addresses compared directly: byte offset over four. A control
    // write is taken only once it is no longer stalled.
    assign ctl_sel = address_i == word_addr(CONTROL_OFFS);
    assign wr_scratch = write_i && address_i == word_addr(SCRATCH_OFFS);
    assign wr_control = write_i && ctl_sel && !ctl_wait;
    assign wr_low = write_i && address_i == word_addr(ADDR_LOW_OFFS);
    assign wr_high = write_i && address_i == word_addr(ADDR_HIGH_OFFS);
    assign reinit_req = wr_control && writedata_i[SOFT_REINIT_BIT];

    soft_reinit_pulse u_reinit (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .req_i(reinit_req),
        .pulse_o(soft_reinit_o)
    );

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------

    // Scratch ignores software reset. The version word has no store, so a
    // write to it is dropped.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scratch_word_reg <= SCRATCH_RST;
        end else if (wr_scratch) begin
            scratch_word_reg <= writedata_i;
        end
    end

    // Software reset forces only the two low enable bits to zero and keeps
    // every other bit. The reinit bit is a trigger and is never stored, so
    // a read-modify-write of the word cannot start a second reset.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_reg <= CONTROL_RST;
        end else if (soft_reinit_o) begin
            control_reg <= control_reg & ~CONTROL_SWRST_CLR;
        end else if (wr_control) begin
            control_reg <= writedata_i & ~REINIT_MASK;
        end
    end

    // Low station-address word, bit for bit onto address bits 0 to 31.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_low_reg <= ADDR_LOW_RST;
        end else if (wr_low) begin
            addr_low_reg <= writedata_i;
        end
    end

    // Upper halfword discarded.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_high_reg <= ADDR_HIGH_RST;
        end else if (wr_high) begin
            addr_high_reg <= writedata_i[ADDR_HIGH_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Unmapped word addresses answer zero rather than stalling the host.
    always_comb begin
        read_next = READ_IDLE;
        case (address_i)
            word_addr(VERSION_OFFS): begin
                read_next = {customer_revision_param,
                             CORE_REVISION};
            end
            word_addr(SCRATCH_OFFS): begin
                read_next = scratch_word_reg;
            end
            word_addr(CONTROL_OFFS): begin
                read_next = control_reg;
            end
            word_addr(ADDR_LOW_OFFS): begin
                read_next = addr_low_reg;
            end
            word_addr(ADDR_HIGH_OFFS): begin
                read_next = {16'h0000, addr_high_reg};
            end
            default: begin
                read_next = READ_IDLE;
            end
        endcase
    end

    // Read data is captured in the stalled first cycle of a read and then
    // stands until the next read is captured, so a slow host still sees it.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            readdata_o <= READ_IDLE;
        end else if (read_i && !read_done_reg) begin
            readdata_o <= read_next;
        end
    end

    // ------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------

    // Straight from the registers, so the core sees no decode glitches.
    assign control_o = control_reg;
    assign station_addr_o = {addr_high_reg, addr_low_reg};

endmodule

/* File: core/mac_csr_pkg.sv */
// Package with offsets, field layouts and reset values of the register head.
package mac_csr_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Byte offsets and the derived word addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] VERSION_OFFS = 12'h000;
    localparam logic [11:0] SCRATCH_OFFS = 12'h004;
    localparam logic [11:0] CONTROL_OFFS = 12'h008;
    localparam logic [11:0] ADDR_LOW_OFFS = 12'h00c;
    localparam logic [11:0] ADDR_HIGH_OFFS = 12'h010;

    // Word address seen on the port: the byte offset shifted right by two.
    function automatic logic [ADDR_W-1:0] word_addr(input logic [11:0] offs);
        word_addr = offs[ADDR_W+1:2];
    endfunction

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CORE_REV_LSB = 0;
    localparam int CUST_REV_LSB = 16;
    localparam int SOFT_REINIT_BIT = 13;
    localparam logic [31:0] CONTROL_SWRST_CLR = 32'h0000_0003;
    localparam int ADDR_HIGH_W = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] ADDR_LOW_RST = 32'h0000_0000;
    localparam logic [15:0] ADDR_HIGH_RST = 16'h0000;

    // Answer for unmapped reads; also the read data held in reset.
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;

endpackage

/* File: core/soft_reinit_pulse.sv */
// Turns a written software-reset bit into a single-cycle reset pulse.
`timescale 1ns/100ps
module soft_reinit_pulse (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Request from the control word write
    input wire logic req_i,
    // One-cycle software reset
    output logic pulse_o
);

    // ------------------------------------------------------------------
    // Pulse register
    // ------------------------------------------------------------------

    // Registered so the reset lands one cycle after the write is taken,
    // which keeps it apart from the store of the control word itself.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= req_i;
        end
    end

endmodule

/* File: sim/csr_host_model.sv */
// Host processor model that issues register reads and writes.
`timescale 1ns/100ps
module csr_host_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [mac_csr_pkg::ADDR_W-1:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [mac_csr_pkg::DATA_W-1:0] writedata_o,
    input wire logic [mac_csr_pkg::DATA_W-1:0] readdata_i,
    input wire logic waitrequest_i
);
    import mac_csr_pkg::*;
    // Idle bus; released lines show the inverse so stale data never passes.
    initial begin
        address_o = 9'h1ff;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'hffff_ffff;
    end
    // Write one word at a byte offset, held until wait is released.
    task automatic wr(input logic [11:0] offs, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        address_o = offs[10:2];
        writedata_o = d;
        write_o = 1'b1;
        do @(posedge clk_i); while (waitrequest_i === 1'b1);
        #1;
        write_o = 1'b0;
        writedata_o = ~d;
        address_o = ~offs[10:2];
    endtask
    // Two writes back to back: the second goes out right after the edge
    // that took the first and is held through any wait cycles.
    task automatic wr2(input logic [11:0] offs, input logic [31:0] d0,
            input logic [31:0] d1);
        @(posedge clk_i);
        #1;
        address_o = offs[10:2];
        writedata_o = d0;
        write_o = 1'b1;
        do @(posedge clk_i); while (waitrequest_i === 1'b1);
        #1;
        writedata_o = d1;
        do @(posedge clk_i); while (waitrequest_i === 1'b1);
        #1;
        write_o = 1'b0;
        writedata_o = ~d1;
        address_o = ~offs[10:2];
    endtask
    // Read one word; data is taken at the edge that sees wait low.
    task automatic rd(input logic [11:0] offs, output logic [31:0] d);
        @(posedge clk_i);
        #1;
        address_o = offs[10:2];
        read_o = 1'b1;
        do @(posedge clk_i); while (waitrequest_i === 1'b1);
        d = readdata_i;
        #1;
        read_o = 1'b0;
        address_o = ~offs[10:2];
    endtask
endmodule

/* File: sim/mac_control_register_head_chk.sv */
// Port checker of the register head.
`timescale 1ns/100ps
module mac_control_register_head_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [mac_csr_pkg::ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [mac_csr_pkg::DATA_W-1:0] writedata_i,
    input wire logic [mac_csr_pkg::DATA_W-1:0] readdata_o,
    input wire logic waitrequest_o,
    // Core side
    input wire logic [31:0] control_o,
    input wire logic [47:0] station_addr_o,
    input wire logic soft_reinit_o
);
    import mac_csr_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Write strobes of the control and address words; a control write
    // counts only at the edge that takes it, with wait-request low.
    logic wr_ctl;
    logic wr_sta;
    assign wr_ctl = write_i && !waitrequest_o && address_i == 9'h002;
    assign wr_sta = write_i && (address_i == 9'h003 || address_i == 9'h004);
    a_hw_reset_zero: assert property (disable iff (1'b0) !rst_n_i |->
        control_o == 32'h0 && station_addr_o == 48'h0 && !soft_reinit_o)
        else $error("outputs not cleared in reset");
    a_ctrl_write: assert property (wr_ctl |=> control_o ==
        ($past(writedata_i) & ~(32'h0000_0001 << SOFT_REINIT_BIT))
        && soft_reinit_o == $past(writedata_i[SOFT_REINIT_BIT]))
        else $error("control write or pulse wrong");
    a_swrst_clear: assert property (soft_reinit_o |=>
        control_o[1:0] == 2'h0 && !soft_reinit_o)
        else $error("soft reset did not clear low bits");
    a_swrst_keep: assert property (soft_reinit_o |=>
        $stable(control_o[31:2]))
        else $error("soft reset touched kept bits");
    a_addr_keep: assert property (!wr_sta |=> $stable(station_addr_o))
        else $error("station address changed without write");
    a_addr_write: assert property (write_i && address_i == 9'h003 |=>
        station_addr_o[31:0] == $past(writedata_i))
        else $error("low address word not written");
    a_read_wait: assert property ($rose(read_i) |->
        waitrequest_o ##1 !waitrequest_o) else $error("read wait wrong");
    a_read_hold: assert property (read_i && !waitrequest_o |=>
        $stable(readdata_o)) else $error("read data did not stand");
    a_write_nowait: assert property (write_i && !read_i |->
        waitrequest_o == (soft_reinit_o && address_i == 9'h002))
        else $error("write stall wrong");
    a_addr_high: assert property (write_i && address_i == 9'h004 |=>
        station_addr_o[47:32] == $past(writedata_i[15:0]))
        else $error("high address word not written");
endmodule
bind mac_control_register_head mac_control_register_head_chk u_chk (
    .clk_i, .rst_n_i, .address_i, .read_i, .write_i, .writedata_i,
    .readdata_o, .waitrequest_o, .control_o, .station_addr_o, .soft_reinit_o);

/* File: sim/mac_control_register_head_tb.sv */
// Self-checking bench of the register head.
`timescale 1ns/100ps
module mac_control_register_head_tb;
    import mac_csr_pkg::*;
    localparam logic [15:0] CUST = 16'h00a5;
    localparam logic [15:0] CORE = 16'h0123; // Arbitrary value.
    logic clk_i;
    logic rst_n_i;
    logic [ADDR_W-1:0] address_i;
    logic read_i;
    logic write_i;
    logic [DATA_W-1:0] writedata_i;
    logic [DATA_W-1:0] readdata_o;
    logic waitrequest_o;
    logic [31:0] control_o;
    logic [47:0] station_addr_o;
    logic soft_reinit_o;
    logic [31:0] rdv;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    mac_control_register_head #(.customer_revision_param(CUST),
        .CORE_REVISION(CORE)) u_mac_control_register_head (.clk_i, .rst_n_i,
        .address_i, .read_i, .write_i, .writedata_i, .readdata_o,
        .waitrequest_o, .control_o, .station_addr_o, .soft_reinit_o);
    csr_host_model u_csr_host_model (.clk_i, .address_o(address_i),
        .read_o(read_i), .write_o(write_i), .writedata_o(writedata_i),
        .readdata_i(readdata_o), .waitrequest_i(waitrequest_o));
    // Free-running clock of 50 ns.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] offs, input logic [31:0] exp);
        u_csr_host_model.rd(offs, rdv);
        check(rdv, exp);
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cut a hang short; the whole sequence needs about a hundred cycles.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // Main sequence.
    initial begin
        rst_n_i = 1'b0;
        repeat (16) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        rchk(12'h000, {CUST, CORE});
        for (int i = 1; i < 5; i++) rchk(12'(i * 4), 32'h0);
        $display("test reset_values done");
        u_csr_host_model.wr(12'h008, 32'h0000_2000);
        u_csr_host_model.wr(12'h004, 32'hdead_beef);
        u_csr_host_model.wr(12'h00c, 32'h1234_5678);
        u_csr_host_model.wr(12'h010, 32'hffff_abcd);
        u_csr_host_model.wr(12'h000, 32'hffff_ffff);
        rchk(12'h004, 32'hdead_beef);
        rchk(12'h00c, 32'h1234_5678);
        rchk(12'h010, 32'h0000_abcd);
        check(32'(station_addr_o[47:32]), 32'h0000_abcd);
        rchk(12'h000, {CUST, CORE});
        rchk(12'h7fc, 32'h0);
        $display("test access done");
        u_csr_host_model.wr(12'h008, 32'hf0f0_0f0f);
        u_csr_host_model.wr(12'h008, 32'hf0f0_2f0f);
        check(32'(soft_reinit_o), 32'h1);
        rchk(12'h008, 32'hf0f0_0f0c);
        rchk(12'h004, 32'hdead_beef);
        rchk(12'h00c, 32'h1234_5678);
        u_csr_host_model.wr(12'h008, 32'hf0f0_0f0f);
        check(control_o, 32'hf0f0_0f0f);
        u_csr_host_model.wr2(12'h008, 32'h0000_2003, 32'h0000_0002);
        rchk(12'h008, 32'h0000_0002);
        $display("test soft_reset done");
        #1 rst_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        for (int i = 1; i < 5; i++) rchk(12'(i * 4), 32'h0);
        $display("test hard_reset done");
        end_of_test();
    end
endmodule
